// ===== hw/dcd_map.svh
// Named constants of the disk command opcode decoder.
// Assumes inclusion by bare name from the top module.
`ifndef DCD_MAP_SVH
`define DCD_MAP_SVH
// Task file register indices
`define DCD_TF_DATA 3'h0
`define DCD_TF_FEAT 3'h1
`define DCD_TF_SCNT 3'h2
`define DCD_TF_SNUM 3'h3
`define DCD_TF_CYLL 3'h4
`define DCD_TF_CYLH 3'h5
`define DCD_TF_DEVH 3'h6
`define DCD_TF_CMD 3'h7
// Field positions
`define DCD_DH_DEV 4
`define DCD_DH_LBA 6
`define DCD_SC_OPT 0
`define DCD_ST_BSY 7
`define DCD_ST_RDY 6
`define DCD_ST_DF 5
`define DCD_ST_DSC 4
`define DCD_ST_DRQ 3
`define DCD_ST_ERR 0
`define DCD_ER_ABT 2
// Opcodes
`define DCD_OP_SLEEP 8'hE6
`define DCD_OP_SLEEP_ALT 8'h99
`define DCD_OP_STBY 8'hE2
`define DCD_OP_STBY_ALT 8'h96
`define DCD_OP_STIM 8'hE0
`define DCD_OP_STIM_ALT 8'h94
`define DCD_OP_SMART 8'hB0
`define DCD_OP_SETF 8'hEF
`define DCD_OP_SETMAX 8'hF9
`define DCD_OP_WBUF 8'hE8
`define DCD_OP_WDMA 8'hCA
`define DCD_OP_WDMA_NR 8'hCB
`define DCD_OP_WDMAQ 8'hCC
`define DCD_OP_WLONG 8'h32
`define DCD_OP_WLONG_NR 8'h33
`define DCD_OP_WMULT 8'hC5
`define DCD_OP_WSECT 8'h30
`define DCD_OP_WSECT_NR 8'h31
// Monitoring subcodes under the monitoring opcode
`define DCD_SM_RD_VAL 8'hD0
`define DCD_SM_RD_THR 8'hD1
`define DCD_SM_AUTOSAVE 8'hD2
`define DCD_SM_SAVE 8'hD3
`define DCD_SM_OFFLINE 8'hD4
`define DCD_SM_RD_LOG 8'hD5
`define DCD_SM_WR_LOG 8'hD6
`define DCD_SM_ENABLE 8'hD8
`define DCD_SM_DISABLE 8'hD9
`define DCD_SM_STATUS 8'hDA
`define DCD_SM_AUTO_OFF 8'hDB
// Set features subcodes
`define DCD_SF_WC_ON 8'h02
`define DCD_SF_XFER 8'h03
`define DCD_SF_APM_ON 8'h05
`define DCD_SF_PUIS_ON 8'h06
`define DCD_SF_SPINUP 8'h07
`define DCD_SF_OFS_ON 8'h09
`define DCD_SF_AAM_ON 8'h42
`define DCD_SF_ECC52 8'h44
`define DCD_SF_LA_OFF 8'h55
`define DCD_SF_RI_ON 8'h5D
`define DCD_SF_REV_OFF 8'h66
`define DCD_SF_WC_OFF 8'h82
`define DCD_SF_APM_OFF 8'h85
`define DCD_SF_PUIS_OFF 8'h86
`define DCD_SF_OFS_OFF 8'h89
`define DCD_SF_LA_ON 8'hAA
`define DCD_SF_ECC4 8'hBB
`define DCD_SF_AAM_OFF 8'hC2
`define DCD_SF_REV_ON 8'hCC
`define DCD_SF_RI_OFF 8'hDD
// Check byte counts and feature defaults
`define DCD_ECC_52 6'h34
`define DCD_ECC_4 6'h04
`define DCD_LA_DEF 1'h1
`define DCD_OFF_DEF 1'h0
`endif

// ===== hw/dcd_pkg.sv
// Types of the disk command opcode decoder.
// Assumes dcd_map.svh on the include path.
package dcd_pkg;
  typedef enum logic [2:0] {
    PR_NONE, PR_PIO_IN, PR_PIO_OUT, PR_NONDATA, PR_DMA, PR_DMAQ
  } dcd_proto_e;
  typedef enum logic [4:0] {
    CM_ABORT, CM_SLEEP, CM_STANDBY, CM_STBY_IMM,
    CM_SM_RD_VAL, CM_SM_RD_THR, CM_SM_AUTOSAVE, CM_SM_SAVE,
    CM_SM_OFFLINE, CM_SM_RD_LOG, CM_SM_WR_LOG, CM_SM_ENABLE,
    CM_SM_DISABLE, CM_SM_STATUS, CM_SM_AUTO_OFF, CM_SET_FEAT,
    CM_WR_BUF, CM_WR_DMA, CM_WR_DMAQ, CM_WR_LONG, CM_WR_MULT,
    CM_WR_SECT, CM_SET_MAX
  } dcd_cmd_e;
  typedef struct packed {
    dcd_cmd_e id;
    dcd_proto_e proto;
  } dcd_cmd_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_BUSY = 3'h2,
    ST_DONE = 3'h4
  } dcd_state_e;
endpackage : dcd_pkg

// ===== hw/dcd_top.sv
// Disk command opcode decoder: task file, command decode, completion.
// Assumes a task file master on sys_clk and a back end on sys_clk that
// answers each dispatched command with one be_done pulse.
//
// Functional notes
// - Monitoring attribute and threshold reads are PIO in
// - Autosave, save, off-line collection are non-data
// - Log read decoded; log write is PIO out
// - Monitor enable, disable, status, auto off-line non-data
// - Features 05/85 set/clear power management
// - Features 06/86 standby power-up; 07 spins up
// - Features 09/89 set/clear address offset mode
// - Features 42/C2 set/clear acoustic management
// - Features 44/BB select 52 or 4 check bytes
// - Features AA/55 turn look-ahead on/off
// - Features 66/CC stop/resume reverting after reset
// - CA/CB are DMA writes, CC queued DMA write
// - 30/31 and C5 are PIO out writes
// - 32/33 long writes use PIO out
// - 99/96/94 alias sleep, standby, standby immediate
// - Respond only when drive-select bit matches
// - Addressing bit selects CHS or LBA fields
// - Retry bit ignored, both codes act alike
// - Option bit used only for set max address
// - Reported register bits are always defined
// - Status and error placed before interrupt
`timescale 1ns/1ps
`default_nettype none
`include "dcd_map.svh"
module dcd_top
  import dcd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Task file port
  input wire logic [2:0] tf_addr,
  input wire logic [7:0] tf_wdata,
  input wire logic tf_wr,
  input wire logic tf_rd,
  output logic [7:0] tf_rdata,
  // Host soft reset pulse and drive position strap pin
  input wire logic srst,
  input wire logic slave_pin,
  // Back end command dispatch
  output logic cmd_stb,
  output dcd_cmd_e cmd_id,
  output dcd_proto_e cmd_proto,
  output logic lba_mode,
  output logic [27:0] lba_addr,
  output logic [15:0] chs_cyl,
  output logic [3:0] chs_head,
  output logic [7:0] chs_sect,
  output logic [7:0] sect_count,
  output logic setmax_opt,
  // Back end completion
  input wire logic be_done,
  input wire logic be_fail,
  input wire logic be_drq,
  // Feature state
  output logic apm_en,
  output logic puis_en,
  output logic spinup,
  output logic offset_en,
  output logic aam_en,
  output logic [5:0] ecc_bytes,
  output logic lookahead_en,
  output logic revert_dis,
  // Host interrupt
  output logic intrq
);

  ////////////////////////////////////////////////////////////////////////
  // Decode functions

  function automatic dcd_cmd_s smart_dec(input logic [7:0] ft);
    dcd_cmd_s c;
    c = '{CM_ABORT, PR_NONE};
    case (ft)
      `DCD_SM_RD_VAL: c = '{CM_SM_RD_VAL, PR_PIO_IN};
      `DCD_SM_RD_THR: c = '{CM_SM_RD_THR, PR_PIO_IN};
      `DCD_SM_AUTOSAVE: c = '{CM_SM_AUTOSAVE, PR_NONDATA};
      `DCD_SM_SAVE: c = '{CM_SM_SAVE, PR_NONDATA};
      `DCD_SM_OFFLINE: c = '{CM_SM_OFFLINE, PR_NONDATA};
      // Log read data phase is outside what is known; taken as PIO in
      `DCD_SM_RD_LOG: c = '{CM_SM_RD_LOG, PR_PIO_IN};
      `DCD_SM_WR_LOG: c = '{CM_SM_WR_LOG, PR_PIO_OUT};
      `DCD_SM_ENABLE: c = '{CM_SM_ENABLE, PR_NONDATA};
      `DCD_SM_DISABLE: c = '{CM_SM_DISABLE, PR_NONDATA};
      `DCD_SM_STATUS: c = '{CM_SM_STATUS, PR_NONDATA};
      `DCD_SM_AUTO_OFF: c = '{CM_SM_AUTO_OFF, PR_NONDATA};
      default: c = '{CM_ABORT, PR_NONE};
    endcase
    return c;
  endfunction : smart_dec

  function automatic logic setf_ok(input logic [7:0] ft);
    case (ft)
      `DCD_SF_WC_ON, `DCD_SF_XFER, `DCD_SF_APM_ON, `DCD_SF_PUIS_ON,
      `DCD_SF_SPINUP, `DCD_SF_OFS_ON, `DCD_SF_AAM_ON, `DCD_SF_ECC52,
      `DCD_SF_LA_OFF, `DCD_SF_RI_ON, `DCD_SF_REV_OFF, `DCD_SF_WC_OFF,
      `DCD_SF_APM_OFF, `DCD_SF_PUIS_OFF, `DCD_SF_OFS_OFF, `DCD_SF_LA_ON,
      `DCD_SF_ECC4, `DCD_SF_AAM_OFF, `DCD_SF_REV_ON,
      `DCD_SF_RI_OFF: setf_ok = 1'b1;
      default: setf_ok = 1'b0;
    endcase
  endfunction : setf_ok

  function automatic dcd_cmd_s cmd_dec(input logic [7:0] op,
                                       input logic [7:0] ft);
    dcd_cmd_s c;
    c = '{CM_ABORT, PR_NONE};
    case (op)
      `DCD_OP_SLEEP, `DCD_OP_SLEEP_ALT: begin
        c = '{CM_SLEEP, PR_NONDATA};
      end
      `DCD_OP_STBY, `DCD_OP_STBY_ALT: begin
        c = '{CM_STANDBY, PR_NONDATA};
      end
      `DCD_OP_STIM, `DCD_OP_STIM_ALT: begin
        c = '{CM_STBY_IMM, PR_NONDATA};
      end
      `DCD_OP_SMART: c = smart_dec(ft);
      `DCD_OP_SETF: begin
        if (setf_ok(ft)) begin
          c = '{CM_SET_FEAT, PR_NONDATA};
        end
      end
      `DCD_OP_SETMAX: c = '{CM_SET_MAX, PR_NONDATA};
      `DCD_OP_WBUF: c = '{CM_WR_BUF, PR_PIO_OUT};
      // Retry and no-retry codes map to one identity
      `DCD_OP_WDMA, `DCD_OP_WDMA_NR: begin
        c = '{CM_WR_DMA, PR_DMA};
      end
      `DCD_OP_WDMAQ: c = '{CM_WR_DMAQ, PR_DMAQ};
      `DCD_OP_WLONG, `DCD_OP_WLONG_NR: begin
        c = '{CM_WR_LONG, PR_PIO_OUT};
      end
      `DCD_OP_WMULT: c = '{CM_WR_MULT, PR_PIO_OUT};
      `DCD_OP_WSECT, `DCD_OP_WSECT_NR: begin
        c = '{CM_WR_SECT, PR_PIO_OUT};
      end
      default: c = '{CM_ABORT, PR_NONE};
    endcase
    return c;
  endfunction : cmd_dec

  ////////////////////////////////////////////////////////////////////////
  // Strap synchroniser: a change counts once stages two and three agree

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic slave_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= slave_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      slave_r <= 1'b0;
    end else if (sync2_r == sync3_r) begin
      slave_r <= sync3_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Task file registers

  logic [7:0] feat_r;
  logic [7:0] scnt_r;
  logic [7:0] snum_r;
  logic [7:0] cyll_r;
  logic [7:0] cylh_r;
  logic [7:0] devh_r;
  dcd_state_e state_r;
  logic busy_r;
  logic err_r;
  logic abt_r;
  logic selected;
  logic acc_cmd;
  dcd_cmd_s dec;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      feat_r <= 8'h00;
      scnt_r <= 8'h00;
      snum_r <= 8'h00;
      cyll_r <= 8'h00;
      cylh_r <= 8'h00;
      devh_r <= 8'h00;
    end else if (tf_wr && !busy_r) begin
      case (tf_addr)
        `DCD_TF_FEAT: feat_r <= tf_wdata;
        `DCD_TF_SCNT: scnt_r <= tf_wdata;
        `DCD_TF_SNUM: snum_r <= tf_wdata;
        `DCD_TF_CYLL: cyll_r <= tf_wdata;
        `DCD_TF_CYLH: cylh_r <= tf_wdata;
        `DCD_TF_DEVH: devh_r <= tf_wdata;
        default: ;
      endcase
    end
  end

  // Both drives see every write; only the addressed one acts
  assign selected = (devh_r[`DCD_DH_DEV] == slave_r);
  assign acc_cmd = tf_wr && (tf_addr == `DCD_TF_CMD) && selected
                   && (state_r == ST_IDLE);
  assign dec = cmd_dec(tf_wdata, feat_r);

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer

  dcd_state_e state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (acc_cmd) begin
          // Unknown codes and feature setting finish without back end
          if (dec.id == CM_ABORT || dec.id == CM_SET_FEAT) begin
            state_nxt = ST_DONE;
          end else begin
            state_nxt = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        if (be_done) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Status and error are final on entry to ST_DONE
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      err_r <= 1'b0;
      abt_r <= 1'b0;
    end else if (state_r == ST_IDLE && acc_cmd) begin
      busy_r <= (dec.id != CM_ABORT) && (dec.id != CM_SET_FEAT);
      err_r <= (dec.id == CM_ABORT);
      abt_r <= (dec.id == CM_ABORT);
    end else if (state_r == ST_BUSY && be_done) begin
      busy_r <= 1'b0;
      err_r <= be_fail;
      abt_r <= be_fail;
    end
  end

  // Raised one cycle after the final status, dropped by a status read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      intrq <= 1'b0;
    end else if (state_r == ST_DONE) begin
      intrq <= 1'b1;
    end else if (acc_cmd ||
                 (tf_rd && tf_addr == `DCD_TF_CMD && selected)) begin
      intrq <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dispatch to the back end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_stb <= 1'b0;
      cmd_id <= CM_ABORT;
      cmd_proto <= PR_NONE;
      lba_mode <= 1'b0;
      lba_addr <= 28'h0000000;
      chs_cyl <= 16'h0000;
      chs_head <= 4'h0;
      chs_sect <= 8'h00;
      sect_count <= 8'h00;
      setmax_opt <= 1'b0;
    end else begin
      cmd_stb <= state_nxt == ST_BUSY && state_r == ST_IDLE;
      if (acc_cmd) begin
        cmd_id <= dec.id;
        cmd_proto <= dec.proto;
        lba_mode <= devh_r[`DCD_DH_LBA];
        lba_addr <= {devh_r[3:0], cylh_r, cyll_r, snum_r};
        chs_cyl <= {cylh_r, cyll_r};
        chs_head <= devh_r[3:0];
        chs_sect <= snum_r;
        sect_count <= scnt_r;
        setmax_opt <= (dec.id == CM_SET_MAX) &&
                      scnt_r[`DCD_SC_OPT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Feature state

  logic setf_go;
  assign setf_go = acc_cmd && (dec.id == CM_SET_FEAT);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      apm_en <= `DCD_OFF_DEF;
      puis_en <= `DCD_OFF_DEF;
      offset_en <= `DCD_OFF_DEF;
      aam_en <= `DCD_OFF_DEF;
      ecc_bytes <= `DCD_ECC_4;
      lookahead_en <= `DCD_LA_DEF;
    end else if (setf_go) begin
      case (feat_r)
        `DCD_SF_APM_ON: apm_en <= 1'b1;
        `DCD_SF_APM_OFF: apm_en <= 1'b0;
        `DCD_SF_PUIS_ON: puis_en <= 1'b1;
        `DCD_SF_PUIS_OFF: puis_en <= 1'b0;
        `DCD_SF_OFS_ON: offset_en <= 1'b1;
        `DCD_SF_OFS_OFF: offset_en <= 1'b0;
        `DCD_SF_AAM_ON: aam_en <= 1'b1;
        `DCD_SF_AAM_OFF: aam_en <= 1'b0;
        `DCD_SF_ECC52: ecc_bytes <= `DCD_ECC_52;
        `DCD_SF_ECC4: ecc_bytes <= `DCD_ECC_4;
        `DCD_SF_LA_ON: lookahead_en <= 1'b1;
        `DCD_SF_LA_OFF: lookahead_en <= 1'b0;
        default: ;
      endcase
    end else if (srst && !revert_dis) begin
      // Power-up-in-standby is kept: it is a non-volatile choice
      apm_en <= `DCD_OFF_DEF;
      offset_en <= `DCD_OFF_DEF;
      aam_en <= `DCD_OFF_DEF;
      ecc_bytes <= `DCD_ECC_4;
      lookahead_en <= `DCD_LA_DEF;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      revert_dis <= 1'b0;
    end else if (setf_go && feat_r == `DCD_SF_REV_OFF) begin
      revert_dis <= 1'b1;
    end else if (setf_go && feat_r == `DCD_SF_REV_ON) begin
      revert_dis <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      spinup <= 1'b0;
    end else begin
      spinup <= setf_go && (feat_r == `DCD_SF_SPINUP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port: every reported bit is a defined value

  logic [7:0] status_v;
  logic [7:0] error_v;
  logic [7:0] rd_nxt;

  always_comb begin
    status_v = 8'h00;
    status_v[`DCD_ST_BSY] = busy_r;
    status_v[`DCD_ST_RDY] = !busy_r;
    status_v[`DCD_ST_DF] = 1'b0;
    status_v[`DCD_ST_DSC] = 1'b1;
    status_v[`DCD_ST_DRQ] = busy_r && be_drq;
    status_v[`DCD_ST_ERR] = err_r;
    error_v = 8'h00;
    error_v[`DCD_ER_ABT] = abt_r;
  end

  always_comb begin
    rd_nxt = 8'h00;
    if (selected) begin
      case (tf_addr)
        `DCD_TF_FEAT: rd_nxt = error_v;
        `DCD_TF_SCNT: rd_nxt = scnt_r;
        `DCD_TF_SNUM: rd_nxt = snum_r;
        `DCD_TF_CYLL: rd_nxt = cyll_r;
        `DCD_TF_CYLH: rd_nxt = cylh_r;
        `DCD_TF_DEVH: rd_nxt = devh_r;
        `DCD_TF_CMD: rd_nxt = status_v;
        default: rd_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tf_rdata <= 8'h00;
    end else if (tf_rd) begin
      tf_rdata <= rd_nxt;
    end else begin
      tf_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  smart_pio_in_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cmd_stb && (cmd_id == CM_SM_RD_VAL || cmd_id == CM_SM_RD_THR)
    |-> cmd_proto == PR_PIO_IN)
    else $error("monitor read not PIO in");

  smart_log_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    acc_cmd && tf_wdata == `DCD_OP_SMART && feat_r == `DCD_SM_WR_LOG
    |=> cmd_stb && cmd_proto == PR_PIO_OUT)
    else $error("log write not dispatched as PIO out");

  abort_seq_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    acc_cmd && dec.id == CM_ABORT
    |=> abt_r && err_r && !busy_r && !cmd_stb ##1 intrq)
    else $error("unknown opcode not aborted");

  irq_order_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(intrq) |-> !busy_r && $past(state_r) == ST_DONE)
    else $error("interrupt before final status");

  desel_ignore_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    tf_wr && tf_addr == `DCD_TF_CMD && !selected && state_r == ST_IDLE
    |=> state_r == ST_IDLE && !cmd_stb)
    else $error("deselected drive acted on command");

  apm_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    setf_go && feat_r == `DCD_SF_APM_ON |=> apm_en [*2])
    else $error("power management not enabled");

  ecc_sel_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    setf_go && feat_r == `DCD_SF_ECC52 |=> ecc_bytes == `DCD_ECC_52)
    else $error("check byte count not 52");

  la_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    setf_go && feat_r == `DCD_SF_LA_OFF |=> !lookahead_en)
    else $error("look-ahead not off");

  revert_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    srst && !setf_go && revert_dis |=> $stable(apm_en)
    && $stable(lookahead_en))
    else $error("features reverted while reverting disabled");

  opt_only_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    setmax_opt |-> cmd_id == CM_SET_MAX)
    else $error("option bit seen outside set max");

  retry_pair_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    acc_cmd && tf_wdata == `DCD_OP_WDMA_NR
    |=> cmd_id == CM_WR_DMA && cmd_proto == PR_DMA)
    else $error("no-retry code decoded differently");

endmodule : dcd_top
`default_nettype wire

// ===== testbench/dcd_be_model.sv
// Back end model: answers each dispatched command after a set latency.
// Assumes the decoder's dispatch strobe and protocol on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dcd_be_model
  import dcd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Dispatch from the decoder
  input wire logic cmd_stb,
  input wire dcd_proto_e cmd_proto,
  // Bench control: latency and failure of the next command
  input wire logic [7:0] lat,
  input wire logic fail_req,
  // Completion to the decoder
  output var logic be_done,
  output logic be_fail,
  output var logic be_drq
);
  logic [7:0] cnt_r;
  logic busy_r;
  logic fail_r;
  // Outside the completion pulse the fail level is not held
  assign be_fail = be_done ? fail_r : ~fail_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 8'h00;
      busy_r <= 1'h0;
      fail_r <= 1'h0;
      be_done <= 1'h0;
      be_drq <= 1'h0;
    end else begin
      be_done <= 1'h0;
      if (cmd_stb) begin
        busy_r <= 1'h1;
        cnt_r <= lat;
        fail_r <= fail_req;
        be_drq <= (cmd_proto != PR_NONDATA) && (cmd_proto != PR_NONE);
      end else if (busy_r) begin
        if (cnt_r == 8'h00) begin
          be_done <= 1'h1;
          busy_r <= 1'h0;
          be_drq <= 1'h0;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end
endmodule : dcd_be_model
`default_nettype wire

// ===== testbench/dcd_tb_top.sv
// Self-checking bench for the command decoder with a back end model.
// Assumes dcd_pkg and the decoder compiled first.
`timescale 1ns/1ps
`default_nettype none
module dcd_tb_top;
  import dcd_pkg::*;
  logic sys_clk = 0, nrst = 0, tf_wr = 0, tf_rd = 0, srst = 0;
  logic slave_pin = 0, fail_req = 0;
  logic [2:0] tf_addr = 3'h0;
  logic [7:0] tf_wdata = 8'h00, lat = 8'h08, tf_rdata, s;
  logic cmd_stb, lba_mode, setmax_opt, be_done, be_fail, be_drq, intrq;
  logic apm_en, puis_en, spinup, offset_en, aam_en, lookahead_en;
  logic revert_dis;
  dcd_cmd_e cmd_id;
  dcd_proto_e cmd_proto;
  logic [27:0] lba_addr;
  logic [15:0] chs_cyl;
  logic [3:0] chs_head;
  logic [7:0] chs_sect, sect_count;
  logic [5:0] ecc_bytes;
  logic [11:0] fx = 12'h012, fx_seen;
  logic [31:0] seed = 32'hE09476FE;
  int n_errors = 0, n_checks = 0;
  logic [7:0] tbl [16] = '{8'hE6, 8'h99, 8'hE2, 8'h96, 8'hE0, 8'h94,
    8'hF9, 8'hE8, 8'hCA, 8'hCB, 8'hCC, 8'h32, 8'h33, 8'hC5, 8'h30, 8'h31};
  logic [7:0] efs [20] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h09,
    8'h42, 8'h44, 8'h55, 8'h5D, 8'h66, 8'h82, 8'h85, 8'h86, 8'h89,
    8'hAA, 8'hBB, 8'hC2, 8'hCC, 8'hDD};
  assign fx_seen = {apm_en, puis_en, offset_en, aam_en, ecc_bytes,
    lookahead_en, revert_dis};
  always #2.5 sys_clk = ~sys_clk;
  dcd_top dcd_top_inst (.sys_clk(sys_clk), .nrst(nrst), .tf_addr(tf_addr),
    .tf_wdata(tf_wdata), .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_rdata(tf_rdata),
    .srst(srst), .slave_pin(slave_pin), .cmd_stb(cmd_stb), .cmd_id(cmd_id),
    .cmd_proto(cmd_proto), .lba_mode(lba_mode), .lba_addr(lba_addr),
    .chs_cyl(chs_cyl), .chs_head(chs_head), .chs_sect(chs_sect),
    .sect_count(sect_count), .setmax_opt(setmax_opt), .be_done(be_done),
    .be_fail(be_fail), .be_drq(be_drq), .apm_en(apm_en), .puis_en(puis_en),
    .spinup(spinup), .offset_en(offset_en), .aam_en(aam_en),
    .ecc_bytes(ecc_bytes), .lookahead_en(lookahead_en),
    .revert_dis(revert_dis), .intrq(intrq));
  dcd_be_model dcd_be_model_inst (.sys_clk(sys_clk), .nrst(nrst),
    .cmd_stb(cmd_stb), .cmd_proto(cmd_proto), .lat(lat),
    .fail_req(fail_req), .be_done(be_done), .be_fail(be_fail),
    .be_drq(be_drq));
  ////////////////////////////////////////////////////////////////////////////
  function logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function dcd_cmd_s dec(input logic [7:0] op, input logic [7:0] ft);
    dcd_cmd_s r;
    r = '{CM_ABORT, PR_NONE};
    case (op)
      8'hE6, 8'h99: r = '{CM_SLEEP, PR_NONDATA};
      8'hE2, 8'h96: r = '{CM_STANDBY, PR_NONDATA};
      8'hE0, 8'h94: r = '{CM_STBY_IMM, PR_NONDATA};
      8'hF9: r = '{CM_SET_MAX, PR_NONDATA};
      8'hE8: r = '{CM_WR_BUF, PR_PIO_OUT};
      8'hCA, 8'hCB: r = '{CM_WR_DMA, PR_DMA};
      8'hCC: r = '{CM_WR_DMAQ, PR_DMAQ};
      8'h32, 8'h33: r = '{CM_WR_LONG, PR_PIO_OUT};
      8'hC5: r = '{CM_WR_MULT, PR_PIO_OUT};
      8'h30, 8'h31: r = '{CM_WR_SECT, PR_PIO_OUT};
      8'hEF: if (ft inside {efs}) r = '{CM_SET_FEAT, PR_NONDATA};
      8'hB0: case (ft)
        8'hD0: r = '{CM_SM_RD_VAL, PR_PIO_IN};
        8'hD1: r = '{CM_SM_RD_THR, PR_PIO_IN};
        8'hD2: r = '{CM_SM_AUTOSAVE, PR_NONDATA};
        8'hD3: r = '{CM_SM_SAVE, PR_NONDATA};
        8'hD4: r = '{CM_SM_OFFLINE, PR_NONDATA};
        8'hD5: r = '{CM_SM_RD_LOG, PR_PIO_IN};
        8'hD6: r = '{CM_SM_WR_LOG, PR_PIO_OUT};
        8'hD8: r = '{CM_SM_ENABLE, PR_NONDATA};
        8'hD9: r = '{CM_SM_DISABLE, PR_NONDATA};
        8'hDA: r = '{CM_SM_STATUS, PR_NONDATA};
        8'hDB: r = '{CM_SM_AUTO_OFF, PR_NONDATA};
        default: ;
      endcase
      default: ;
    endcase
    return r;
  endfunction : dec
  ////////////////////////////////////////////////////////////////////////////
  task end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    tf_wr <= 1'h1;
    tf_addr <= a;
    tf_wdata <= d;
    @(posedge sys_clk);
    tf_wr <= 1'h0;
  endtask : wr
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    tf_rd <= 1'h1;
    tf_addr <= a;
    @(posedge sys_clk);
    tf_rd <= 1'h0;
    #1 d = tf_rdata;
  endtask : rd
  task sf(input logic [7:0] ft);
    case (ft)
      8'h05, 8'h85: fx[11] = !ft[7];
      8'h06, 8'h86: fx[10] = !ft[7];
      8'h09, 8'h89: fx[9] = !ft[7];
      8'h42, 8'hC2: fx[8] = !ft[7];
      8'h44: fx[7:2] = 6'h34;
      8'hBB: fx[7:2] = 6'h04;
      8'hAA, 8'h55: fx[1] = ft[7];
      8'h66, 8'hCC: fx[0] = !ft[7];
      default: ;
    endcase
  endtask : sf
  // Full command: task file, command, wait for interrupt, status readback
  task cmd(input logic [7:0] op, input logic [7:0] ft,
           input logic [7:0] dh, input logic [7:0] sc);
    logic [7:0] st, sn, cl, ch;
    dcd_cmd_s x;
    int k;
    logic fl;
    x = dec(op, ft);
    seed = lfsr(seed);
    {sn, cl, ch} = seed[23:0];
    wr(3'h1, ft);
    wr(3'h2, sc);
    wr(3'h3, sn);
    wr(3'h4, cl);
    wr(3'h5, ch);
    wr(3'h6, dh);
    wr(3'h7, op);
    #1;
    if (x.id == CM_ABORT || x.id == CM_SET_FEAT) begin
      chk(cmd_stb, 0);
      chk({cmd_id, cmd_proto}, x);
    end else begin
      chk(cmd_stb, 1);
      chk({cmd_id, cmd_proto}, x);
      chk({lba_mode, lba_addr}, {dh[6], dh[3:0], ch, cl, sn});
      chk({chs_cyl, chs_head, chs_sect}, {ch, cl, dh[3:0], sn});
      chk({sect_count, setmax_opt}, {sc, op == 8'hF9 && sc[0]});
      if (lat > 8'h05) begin
        rd(3'h7, st);
        chk(st, x.proto == PR_NONDATA ? 8'h90 : 8'h98);
      end
    end
    chk(spinup, x.id == CM_SET_FEAT && ft == 8'h07);
    if (x.id == CM_SET_FEAT) sf(ft);
    k = 0;
    while (intrq !== 1'b1 && k < 300) begin
      @(posedge sys_clk);
      #1 k++;
    end
    if (k == 300) begin
      n_errors++;
      $display("[FAIL] %0t no completion", $time);
      end_sim();
    end
    fl = x.id == CM_ABORT || (x.id != CM_SET_FEAT && fail_req);
    rd(3'h7, st);
    chk(st, fl ? 8'h51 : 8'h50);
    rd(3'h1, st);
    chk(st, fl ? 8'h04 : 8'h00);
    chk({intrq, fx_seen}, {1'b0, fx});
  endtask : cmd
  task soft_reset();
    @(posedge sys_clk);
    srst <= 1'h1;
    @(posedge sys_clk);
    srst <= 1'h0;
    #1;
    if (!fx[0]) fx = {1'b0, fx[10], 2'b00, 6'h04, 2'b10};
    chk(fx_seen, fx);
  endtask : soft_reset
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'h1;
    #1 chk({intrq, cmd_id, fx_seen}, {1'b0, CM_ABORT, fx});
    for (int i = 0; i < 16; i++) cmd(tbl[i], 8'h00, 8'hE0, 8'h01);
    for (int i = 0; i < 12; i++) cmd(8'hB0, 8'(8'hD0 + i), 8'hA0, 8'h00);
    for (int i = 0; i < 20; i++) cmd(8'hEF, efs[i], 8'hA0, 8'h00);
    cmd(8'hEF, 8'h05, 8'hA0, 8'h00);
    soft_reset();
    cmd(8'hEF, 8'h66, 8'hA0, 8'h00);
    cmd(8'hEF, 8'h09, 8'hA0, 8'h00);
    soft_reset();
    // Deselected drive: command ignored, reads give zero
    wr(3'h6, 8'h10);
    wr(3'h7, 8'hE6);
    repeat (3) @(posedge sys_clk);
    #1 chk({cmd_stb, intrq}, 0);
    rd(3'h7, s);
    chk(s, 8'h00);
    slave_pin <= 1'h1;
    repeat (5) @(posedge sys_clk);
    cmd(8'hCA, 8'h00, 8'hF0, 8'h00);
    slave_pin <= 1'h0;
    repeat (5) @(posedge sys_clk);
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      lat <= {4'h0, seed[3:0]};
      fail_req <= seed[4];
      case (seed[6:5])
        2'h0: s = tbl[seed[10:7]];
        2'h1: s = 8'hB0;
        2'h2: s = 8'hEF;
        default: s = seed[15:8];
      endcase
      cmd(s, s == 8'hB0 ? {4'hD, seed[19:16]} : seed[23:16],
          {seed[31:29], 1'b0, seed[28:25]}, seed[31:24]);
    end
    end_sim();
  end
endmodule : dcd_tb_top
`default_nettype wire
